// *** loopback_clock_select_regs.svh ***
`ifndef LOOPBACK_CLOCK_SELECT_REGS_SVH
`define LOOPBACK_CLOCK_SELECT_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define ADDR_W 18
`define MAC0_LCS_OFFSET 18'h130c8
`define MAC2_LCS_OFFSET 18'h132c8
`define MAC4_LCS_OFFSET 18'h134c8
`define MAC6_LCS_OFFSET 18'h136c8
`define IRQ_STATUS_OFFSET 18'h13000
`define IRQ_MASK_OFFSET 18'h13004

// ==========================================================
// Reset values
`define CTL_RESET 32'h7fff_0000
`define IRQ_RESET 8'h00

// ==========================================================
// Status bit positions
`define ST_DEAD_LSB 0
`define ST_UP_LSB 4

// ==========================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ==========================================================
// Timing
`define CLK_NS 5
`define DLT_UNIT_NS (8192 * 10)
`define DLT_TICK_CYCLES (`DLT_UNIT_NS / `CLK_NS)
`define SILENCE_NS 400
`define SILENCE_CYCLES (`SILENCE_NS / `CLK_NS)
`define BOOT_LOAD_CNT 2'h2

`endif

// *** loopback_clock_select_pkg.sv ***
package loopback_clock_select_pkg;

  // ==========================================================
  // Per-MAC control word, most significant field first
  typedef struct packed {
    logic dead_link_timer_enable;
    logic [14:0] dead_link_threshold;
    logic [3:0] per_lane_line_loopback;
    logic spare;
    logic port_split_select;
    logic odd_port_local_loopback;
    logic even_port_local_loopback;
    logic tx_lane_reverse;
    logic rx_lane_reverse;
    logic odd_port_soft_reset;
    logic even_port_soft_reset;
    logic odd_port_power_down;
    logic even_port_power_down;
    logic [1:0] lane_rate;
  } mac_ctl_t;

  // ==========================================================
  // Strap pins
  typedef struct packed {
    logic [3:0] port_split_strap;
    logic [7:0] port_power_down_strap;
    logic tx_reverse_strap;
    logic rx_reverse_strap;
    logic [1:0] lane_rate_strap;
  } strap_t;

  // ==========================================================
  // Per-port controls
  typedef struct packed {
    logic hold_reset;
    logic power_down;
    logic local_loopback;
    logic tx_flush;
    logic tx_drop;
  } port_ctl_t;

  // ==========================================================
  // Dead link timer states
  typedef enum logic [1:0] {
    DLT_IDLE,
    DLT_COUNT,
    DLT_DEAD
  } dlt_state_t;

endpackage

// *** sync2.sv ***
`timescale 1ns/1ps

// ==========================================================
// Two-flop synchroniser
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // sync2

// *** dead_link_timer.sv ***
`timescale 1ns/1ps
`include "loopback_clock_select_regs.svh"

// ==========================================================
// Dead link timer for one MAC
module dead_link_timer
  import loopback_clock_select_pkg::*;
#(
  parameter int TICK_CYCLES = `DLT_TICK_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic enable,
  input wire logic [14:0] threshold,
  // Link state
  input wire logic silence_start,
  input wire logic link_up,
  // Result
  output logic dead,
  output logic declare,
  output logic recover
);

  dlt_state_t state_r;
  logic [15:0] pre_r;
  logic [14:0] cnt_r;
  logic tick;

  // RULE5: tick every 8192 units
  assign tick = (pre_r == 16'(TICK_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || state_r != DLT_COUNT || silence_start || tick) begin
      pre_r <= 16'h0000;
    end else begin
      pre_r <= pre_r + 16'h0001;
    end
  end

  // ==========================================================
  // State machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= DLT_IDLE;
      cnt_r <= 15'h0000;
      dead <= 1'b0;
      declare <= 1'b0;
      recover <= 1'b0;
    end else begin
      declare <= 1'b0;
      recover <= 1'b0;
      unique case (state_r)
        DLT_IDLE: begin
          // RULE4: reload on silence
          if (enable && silence_start) begin
            cnt_r <= threshold;
            state_r <= DLT_COUNT;
          end
        end
        DLT_COUNT: begin
          if (!enable || link_up) begin
            state_r <= DLT_IDLE;
          end else if (silence_start) begin
            cnt_r <= threshold;
          end else if (tick) begin
            // RULE4: zero declares dead
            if (cnt_r == 15'h0000) begin
              state_r <= DLT_DEAD;
              dead <= 1'b1;
              declare <= 1'b1;
            end else begin
              cnt_r <= cnt_r - 15'h0001;
            end
          end
        end
        DLT_DEAD: begin
          // RULE2: dead until link up or enable drops
          if (!enable || link_up) begin
            state_r <= DLT_IDLE;
            dead <= 1'b0;
            recover <= link_up;
          end
        end
        default: begin
          state_r <= DLT_IDLE;
        end
      endcase
    end
  end

endmodule // dead_link_timer

// *** mac_loopback_clock_select.sv ***
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "loopback_clock_select_regs.svh"

// Behaviour
// RULE1: Dead link timer runs only while its enable bit is set; reset clears it.
// RULE2: A dead link flushes the transmit queue and drops new packets until link up.
// RULE3: Silence on either port of the MAC feeds detection, not only lane 0. The code counts the odd port only while port split select is set.
// RULE4: Each silence reloads the counter from threshold; reaching zero declares dead.
// RULE5: Timeout is 8192 times threshold plus one 10 ns units; threshold resets all ones.
// RULE6: A zero threshold keeps the counter disabled even when enabled.
// RULE7: Four bits enable line loopback per lane, D C B A from top.
// RULE8: Port split bit loads from its strap at reset; writes override.
// RULE9: Odd port local loopback bit loops transmit to receive before the encoder.
// RULE10: Even port local loopback bit loops transmit to receive before the encoder.
// RULE11: Transmit lane reverse bit loads from its strap; writable by software.
// RULE12: Receive lane reverse bit loads from its strap; writable by software.
// RULE13: Odd soft reset holds odd port logic in reset, transceiver untouched.
// RULE14: Even soft reset holds even port logic in reset, transceiver untouched.
// RULE15: Odd power down loads from strap, writable; one powers odd port down.
// RULE16: Even power down loads from strap; powers even down and resets odd.
// RULE17: Lane rate field loads from strap and is writable; code three reserved.
// RULE18: Straps are captured once after reset release, then only software writes.
module mac_loopback_clock_select
  import loopback_clock_select_pkg::*;
#(
  parameter int TICK_CYCLES = `DLT_TICK_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // Write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // Read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link clocks from the partner, one per port
  input wire logic [7:0] link_clk,
  // Strap pins
  input wire strap_t straps,
  // Per-MAC and per-port controls
  output mac_ctl_t [3:0] mac_ctl,
  output port_ctl_t [7:0] port_ctl,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Declarations
  mac_ctl_t ctl_r [4];
  mac_ctl_t ctl_strap [4];
  mac_ctl_t ctl_merge [4];
  logic [`ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [31:0] wmask;
  logic [3:0] wstrb_r;
  logic aw_full_r;
  logic w_full_r;
  logic aw_full_nxt;
  logic w_full_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;
  logic do_write;
  logic [3:0] wr_mac;
  logic wr_status;
  logic wr_mask;
  logic wr_hit;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] mask_r;
  logic [7:0] events;
  logic [1:0] boot_cnt_r;
  logic strap_load;
  strap_t straps_s;
  logic [7:0] link_s;
  logic [7:0] link_prev_r;
  logic [6:0] idle_cnt_r [8];
  logic [7:0] port_silent;
  logic [7:0] port_active;
  logic [3:0] mac_silent;
  logic [3:0] mac_silent_r;
  logic [3:0] dead;
  logic [3:0] declare;
  logic [3:0] recover;

  // ==========================================================
  // Synchronisers
  sync2 #(
    .WIDTH($bits(strap_t))
  ) u_strap_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(straps),
    .q(straps_s)
  );

  sync2 #(
    .WIDTH(8)
  ) u_link_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(link_clk),
    .q(link_s)
  );

  // ==========================================================
  // Strap capture after reset release
  // RULE18: single load after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_cnt_r <= 2'h0;
    end else if (boot_cnt_r != 2'h3) begin
      boot_cnt_r <= boot_cnt_r + 2'h1;
    end
  end

  assign strap_load = (boot_cnt_r == `BOOT_LOAD_CNT);

  // ==========================================================
  // Write channel acceptance
  assign do_write = aw_full_r & w_full_r & ~bvalid;
  assign aw_full_nxt = (aw_full_r | (awvalid & awready)) & ~do_write;
  assign w_full_nxt = (w_full_r | (wvalid & wready)) & ~do_write;
  assign bvalid_nxt = do_write | (bvalid & ~bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready <= ~aw_full_nxt & ~bvalid_nxt;
      wready <= ~w_full_nxt & ~bvalid_nxt;
      bvalid <= bvalid_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_write) begin
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Write decode
  always_comb begin
    wr_mac = 4'h0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    unique case (awaddr_r)
      `MAC0_LCS_OFFSET: wr_mac[0] = do_write;
      `MAC2_LCS_OFFSET: wr_mac[1] = do_write;
      `MAC4_LCS_OFFSET: wr_mac[2] = do_write;
      `MAC6_LCS_OFFSET: wr_mac[3] = do_write;
      `IRQ_STATUS_OFFSET: wr_status = do_write;
      `IRQ_MASK_OFFSET: wr_mask = do_write;
      default: wr_mac = 4'h0;
    endcase
  end

  assign wr_hit = (|wr_mac) | wr_status | wr_mask;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // ==========================================================
  // Control registers, one per MAC
  for (genvar m = 0; m < 4; m++) begin : g_mac
    always_comb begin
      ctl_merge[m] = (ctl_r[m] & ~wmask) | (wdata_r & wmask);
      ctl_strap[m] = ctl_r[m];
      // RULE8: port split from strap
      ctl_strap[m].port_split_select = straps_s.port_split_strap[m];
      // RULE11: transmit reverse from strap
      ctl_strap[m].tx_lane_reverse = straps_s.tx_reverse_strap;
      // RULE12: receive reverse from strap
      ctl_strap[m].rx_lane_reverse = straps_s.rx_reverse_strap;
      // RULE15: odd power down strap
      ctl_strap[m].odd_port_power_down = straps_s.port_power_down_strap[2*m+1];
      // RULE16: even power down strap
      ctl_strap[m].even_port_power_down = straps_s.port_power_down_strap[2*m];
      // RULE17: lane rate from strap
      ctl_strap[m].lane_rate = straps_s.lane_rate_strap;
    end

    // RULE5: threshold resets all ones
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ctl_r[m] <= `CTL_RESET;
      end else if (strap_load) begin
        ctl_r[m] <= ctl_strap[m];
      end else if (wr_mac[m]) begin
        ctl_r[m] <= ctl_merge[m];
      end
    end

    // RULE7: lane loopback and lane controls out
    assign mac_ctl[m] = ctl_r[m];

    // RULE3: even port, odd port only while port split select is set
    assign mac_silent[m] = (port_active[2*m] & port_silent[2*m])
      | (port_active[2*m+1] & ctl_r[m].port_split_select & port_silent[2*m+1]);

    // RULE1: timer gated by enable
    // RULE6: zero threshold disables
    dead_link_timer #(
      .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(ctl_r[m].dead_link_timer_enable && ctl_r[m].dead_link_threshold != 15'h0000),
      .threshold(ctl_r[m].dead_link_threshold),
      .silence_start(mac_silent[m] & ~mac_silent_r[m]),
      .link_up(~mac_silent[m]),
      .dead(dead[m]),
      .declare(declare[m]),
      .recover(recover[m])
    );
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mac_silent_r <= 4'h0;
    end else begin
      mac_silent_r <= mac_silent;
    end
  end

  // ==========================================================
  // Silence detection per port
  for (genvar p = 0; p < 8; p++) begin : g_port
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        link_prev_r[p] <= 1'b0;
        idle_cnt_r[p] <= 7'h00;
      end else begin
        link_prev_r[p] <= link_s[p];
        if (link_s[p] != link_prev_r[p]) begin
          idle_cnt_r[p] <= 7'h00;
        end else if (idle_cnt_r[p] != 7'(`SILENCE_CYCLES)) begin
          idle_cnt_r[p] <= idle_cnt_r[p] + 7'h01;
        end
      end
    end

    assign port_silent[p] = (idle_cnt_r[p] == 7'(`SILENCE_CYCLES));
    assign port_active[p] = ~port_ctl[p].power_down & ~port_ctl[p].hold_reset;

    // ==========================================================
    // Per-port control outputs
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        port_ctl[p] <= '0;
      end else if (p % 2 == 1) begin
        // RULE13: odd soft reset, transceiver kept
        // RULE16: even power down resets odd
        port_ctl[p].hold_reset <= ctl_r[p/2].odd_port_soft_reset
          | ctl_r[p/2].even_port_power_down;
        // RULE15: odd power down
        port_ctl[p].power_down <= ctl_r[p/2].odd_port_power_down;
        // RULE9: odd local loopback
        port_ctl[p].local_loopback <= ctl_r[p/2].odd_port_local_loopback;
        // RULE2: flush and drop when dead
        port_ctl[p].tx_flush <= declare[p/2];
        port_ctl[p].tx_drop <= dead[p/2];
      end else begin
        // RULE14: even soft reset, transceiver kept
        port_ctl[p].hold_reset <= ctl_r[p/2].even_port_soft_reset;
        // RULE16: even power down
        port_ctl[p].power_down <= ctl_r[p/2].even_port_power_down;
        // RULE10: even local loopback
        port_ctl[p].local_loopback <= ctl_r[p/2].even_port_local_loopback;
        // RULE2: flush and drop when dead
        port_ctl[p].tx_flush <= declare[p/2];
        port_ctl[p].tx_drop <= dead[p/2];
      end
    end
  end

  // ==========================================================
  // Interrupt status and mask
  assign events = {recover, declare};

  always_comb begin
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = status_r & ~(wdata_r[7:0] & wmask[7:0]);
    end
    status_nxt = status_nxt | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= `IRQ_RESET;
      mask_r <= `IRQ_RESET;
      irq <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (wr_mask) begin
        mask_r <= (mask_r & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]);
      end
      irq <= |(status_r & mask_r);
    end
  end

  // ==========================================================
  // Read channel
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (araddr)
      `MAC0_LCS_OFFSET: rd_data = ctl_r[0];
      `MAC2_LCS_OFFSET: rd_data = ctl_r[1];
      `MAC4_LCS_OFFSET: rd_data = ctl_r[2];
      `MAC6_LCS_OFFSET: rd_data = ctl_r[3];
      `IRQ_STATUS_OFFSET: rd_data = {24'h000000, status_r};
      `IRQ_MASK_OFFSET: rd_data = {24'h000000, mask_r};
      default: rd_hit = 1'b0;
    endcase
  end

  assign rvalid_nxt = (arvalid & arready) | (rvalid & ~rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else begin
      rvalid <= rvalid_nxt;
      arready <= ~rvalid_nxt & ~(arvalid & arready);
      if (arvalid && arready) begin
        rdata <= rd_data;
        rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

endmodule // mac_loopback_clock_select

// *** mac_loopback_clock_select_properties.sv ***
`timescale 1ns/1ps
`include "loopback_clock_select_regs.svh"

// ==========================================================
// Checker on the top ports
module mac_loopback_clock_select_properties
  import loopback_clock_select_pkg::*;
#(
  parameter int TICK_CYCLES = `DLT_TICK_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Link, straps and controls
  input wire logic [7:0] link_clk,
  input wire strap_t straps,
  input wire mac_ctl_t [3:0] mac_ctl,
  input wire port_ctl_t [7:0] port_ctl,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [2:0] rel_r;

  // Cycles since reset release, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) rel_r <= 3'h0;
    else if (rel_r != 3'h7) rel_r <= rel_r + 3'h1;
  end

  property p_flush_en;
    port_ctl[0].tx_flush |-> $past(mac_ctl[0].dead_link_timer_enable, 2);
  endproperty
  a_flush_en: assert property (p_flush_en) else $error("flush while disabled");
  property p_flush_thr;
    port_ctl[0].tx_flush |-> $past(mac_ctl[0].dead_link_threshold, 2) != 15'h0000;
  endproperty
  a_flush_thr: assert property (p_flush_thr) else $error("flush with zero threshold");
  property p_flush_drop;
    port_ctl[0].tx_flush |-> ##[0:2] (port_ctl[0].tx_drop && port_ctl[1].tx_drop);
  endproperty
  a_flush_drop: assert property (p_flush_drop) else $error("no drop on both ports");
  property p_odd_lb;
    port_ctl[1].local_loopback == $past(mac_ctl[0].odd_port_local_loopback);
  endproperty
  a_odd_lb: assert property (p_odd_lb) else $error("odd loopback wrong");
  property p_even_lb;
    port_ctl[0].local_loopback == $past(mac_ctl[0].even_port_local_loopback);
  endproperty
  a_even_lb: assert property (p_even_lb) else $error("even loopback wrong");
  property p_odd_hold;
    port_ctl[1].hold_reset ==
      $past(mac_ctl[0].odd_port_soft_reset || mac_ctl[0].even_port_power_down);
  endproperty
  a_odd_hold: assert property (p_odd_hold) else $error("odd hold wrong");
  property p_even_hold;
    port_ctl[0].hold_reset == $past(mac_ctl[0].even_port_soft_reset);
  endproperty
  a_even_hold: assert property (p_even_hold) else $error("even hold wrong");
  property p_reset_thr;
    $rose(aresetn) |-> mac_ctl[0].dead_link_threshold == 15'h7fff
      && !mac_ctl[0].dead_link_timer_enable;
  endproperty
  a_reset_thr: assert property (p_reset_thr) else $error("reset value wrong");
  property p_strap_load;
    rel_r == 3'h6 |-> mac_ctl[0].lane_rate == straps.lane_rate_strap
      && mac_ctl[0].port_split_select == straps.port_split_strap[0]
      && mac_ctl[0].tx_lane_reverse == straps.tx_reverse_strap
      && mac_ctl[0].rx_lane_reverse == straps.rx_reverse_strap
      && mac_ctl[0].odd_port_power_down == straps.port_power_down_strap[1];
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not loaded");
  property p_write_only;
    rel_r == 3'h7 && !$stable(mac_ctl) |-> $rose(bvalid);
  endproperty
  a_write_only: assert property (p_write_only) else $error("control changed");

  c_flush: cover property (port_ctl[0].tx_flush);
  c_irq: cover property (irq);
  c_slverr: cover property (rvalid && rresp == `RESP_SLVERR);
endmodule // mac_loopback_clock_select_properties

bind mac_loopback_clock_select mac_loopback_clock_select_properties #(
  .TICK_CYCLES(TICK_CYCLES)
) mac_loopback_clock_select_properties_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
  .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .link_clk, .straps, .mac_ctl, .port_ctl, .irq);

// *** link_partner_model.sv ***
`timescale 1ns/1ps

// ==========================================================
// Remote link partners, one clock per port, still when silent
module link_partner_model (
  // Control
  input wire logic [7:0] active,
  // Link clocks
  output logic [7:0] link_clk
);
  initial begin
    link_clk = 8'h00;
    forever begin
      #40;
      link_clk = link_clk ^ active;
    end
  end
endmodule // link_partner_model

// *** mac_loopback_clock_select_tb.sv ***
`timescale 1ns/1ps
`include "loopback_clock_select_regs.svh"

module mac_loopback_clock_select_tb;
  import loopback_clock_select_pkg::*;
  localparam int TICK = 4;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq, dead;
  logic [`ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic [7:0] link_clk, active;
  strap_t straps;
  mac_ctl_t [3:0] mac_ctl;
  port_ctl_t [7:0] port_ctl;
  integer seed, bad_count, compares, n;
  logic [17:0] ofs [4] = '{`MAC0_LCS_OFFSET, `MAC2_LCS_OFFSET, `MAC4_LCS_OFFSET, `MAC6_LCS_OFFSET};
  logic [14:0] thr_t [5] = '{15'h3, 15'h0, 15'h3, 15'h3, 15'h3};
  bit en_t [5] = '{1, 1, 0, 1, 1};
  bit sp_t [5] = '{0, 0, 0, 1, 0};
  int pt_t [5] = '{0, 0, 0, 1, 1};

  mac_loopback_clock_select #(.TICK_CYCLES(TICK)) mac_loopback_clock_select_i (.aclk, .aresetn,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .link_clk, .straps,
    .mac_ctl, .port_ctl, .irq);
  link_partner_model link_partner_model_i (.active, .link_clk);

  // ==========================================================
  // Clock, watchdog, checking
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    #100000;
    bad_count++;
    finish_test;
  end
  task automatic finish_test;
    if (bad_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // Bus master
  task automatic axi_write(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // ==========================================================
  // Expected values
  function automatic logic [31:0] ctl_exp(input int m);
    mac_ctl_t c;
    c = mac_ctl_t'(`CTL_RESET);
    c.port_split_select = straps.port_split_strap[m];
    c.tx_lane_reverse = straps.tx_reverse_strap;
    c.rx_lane_reverse = straps.rx_reverse_strap;
    c.odd_port_power_down = straps.port_power_down_strap[2*m+1];
    c.even_port_power_down = straps.port_power_down_strap[2*m];
    c.lane_rate = straps.lane_rate_strap;
    return c;
  endfunction
  function automatic logic [4:0] port_exp(input mac_ctl_t c, input bit odd);
    if (odd) return {c.odd_port_soft_reset | c.even_port_power_down, c.odd_port_power_down,
      c.odd_port_local_loopback, 2'b00};
    return {c.even_port_soft_reset, c.even_port_power_down, c.even_port_local_loopback, 2'b00};
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h0c02;
    bad_count = 0; compares = 0;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf; active = 8'hff;
    rnd = $random(seed);
    straps = rnd[15:0];
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    for (int m = 0; m < 4; m++) begin
      axi_read(ofs[m], rd, rsp);
      check(rd, ctl_exp(m));
    end
    axi_read(`IRQ_MASK_OFFSET, rd, rsp);
    check(rd, 32'h0);
    for (int i = 0; i < 12; i++) begin
      rnd = $random(seed);
      rnd[31] = 1'b0;
      if (i < 4) rnd[1:0] = 2'h3;
      axi_write(ofs[i%4], rnd, rsp);
      check(rsp, `RESP_OKAY);
      axi_read(ofs[i%4], rd, rsp);
      check(rd, rnd);
      check(rsp, `RESP_OKAY);
      check(mac_ctl[i%4], rnd);
      check(port_ctl[2*(i%4)] & 5'h1c, port_exp(rnd, 0));
      check(port_ctl[2*(i%4)+1] & 5'h1c, port_exp(rnd, 1));
    end
    axi_write(ofs[0], 32'h1234_5678, rsp);
    wstrb <= 4'h5;
    axi_write(ofs[0], 32'h0000_0000, rsp);
    wstrb <= 4'hf;
    axi_read(ofs[0], rd, rsp);
    check(rd, 32'h1200_5600);
    axi_write(18'h00100, 32'hffffffff, rsp);
    check(rsp, `RESP_SLVERR);
    axi_read(18'h00100, rd, rsp);
    check(rsp, `RESP_SLVERR);
    check(rd, 32'h0);
    axi_write(`IRQ_MASK_OFFSET, 32'h01, rsp);
    for (int i = 0; i < 5; i++) begin
      dead = en_t[i] && thr_t[i] != 15'h0 && (pt_t[i] == 0 || sp_t[i]);
      axi_write(`IRQ_STATUS_OFFSET, 32'hff, rsp);
      axi_write(`MAC0_LCS_OFFSET, {en_t[i], thr_t[i], 5'h0, sp_t[i], 10'h0}, rsp);
      active <= ~(8'h01 << pt_t[i]);
      n = 0;
      while (!port_ctl[0].tx_flush && n < 300) begin
        @(posedge aclk);
        n++;
      end
      check(n < 300, dead);
      if (dead) begin
        check(n >= 72 + 4 * TICK && n <= 90 + 4 * TICK, 1);
        repeat (2) @(posedge aclk);
        check({port_ctl[0].tx_drop, port_ctl[1].tx_drop, irq}, 3'h7);
        axi_read(`IRQ_STATUS_OFFSET, rd, rsp);
        check(rd & 32'h11, 32'h01);
        axi_write(`IRQ_STATUS_OFFSET, 32'h01, rsp);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
      end
      active <= 8'hff;
      repeat (120) @(posedge aclk);
      check(port_ctl[0].tx_drop, 1'b0);
      axi_read(`IRQ_STATUS_OFFSET, rd, rsp);
      check({rd[4], irq}, {dead, 1'b0});
    end
    finish_test;
  end
endmodule // mac_loopback_clock_select_tb
